// ===== verilog/fbpes_pkg.sv
// fbpes_pkg: constants, command codes, status bit positions and host order codes
// assumes a single 20 MHz clock shared by both ends of the flash command link
package fbpes_pkg;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 16;
  localparam int SECT_W    = 6;
  localparam int PAGE_W    = 7;
  localparam int IDX_W     = 5;
  localparam int WORD_W    = 6;
  localparam int SECTS     = 64;
  localparam int BUF_WORDS = 32;
  localparam int UNLK_W    = 11;
  localparam int BANK_BIT  = 11;

  localparam logic [UNLK_W-1:0] ADR_UNLK1 = 11'h555;
  localparam logic [UNLK_W-1:0] ADR_UNLK2 = 11'h2AA;

  localparam logic [DATA_W-1:0] CMD_UNLK1       = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLK2       = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD    = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_CONFIRM     = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECT_ERASE  = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_SUSPEND     = 16'h00B0;
  localparam logic [DATA_W-1:0] CMD_RESUME      = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_RESET       = 16'h00F0;
  localparam logic [DATA_W-1:0] BUF_MAX_CNT     = 16'h001F;
  localparam logic [DATA_W-1:0] ERASED_WORD     = 16'hFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD       = 16'h0000;
  localparam logic [WORD_W-1:0] SECT_LAST       = 6'h3F;
  localparam logic [SECT_W-1:0] SECT_MAX        = 6'h3F;
  localparam logic [IDX_W-1:0]  IDX_LAST        = 5'h1F;

  // status word bit positions
  localparam int STS_POLL = 7;
  localparam int STS_TOG  = 6;
  localparam int STS_TLE  = 5;
  localparam int STS_EAT  = 3;
  localparam int STS_ETOG = 2;
  localparam int STS_BABT = 1;

  // erase accept window, least time, rounded up to whole cycles
  localparam int CLK_NS    = 50;
  localparam int EAW_NS    = 50000;
  localparam int EAW_W     = 10;
  localparam int EAW_CYC_I = (EAW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [EAW_W-1:0] EAW_CYC = EAW_W'(EAW_CYC_I);
  localparam logic [EAW_W-1:0] EAW_ONE = 10'h001;

  typedef enum logic [2:0] {
    OP_READ, OP_BUF_PROG, OP_ERASE, OP_ERASE_ADD, OP_ABORT_RST, OP_SUSPEND, OP_RESUME
  } fbpes_op_t;
endpackage

// ===== verilog/fbpes_if.sv
// fbpes_if: word-wide flash command link between host controller and device
// assumes both ends run on core_clk_i; strobes are one cycle, read data one cycle later
`timescale 1ns/1ps
interface fbpes_if;
  logic                          wr;
  logic                          rd;
  logic [fbpes_pkg::ADDR_W-1:0]  addr;
  logic [fbpes_pkg::DATA_W-1:0]  wdata;
  logic [fbpes_pkg::DATA_W-1:0]  rdata;
  modport dev_mp  (input wr, input rd, input addr, input wdata, output rdata);
  modport host_mp (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ===== verilog/fbpes_timer.sv
// fbpes_timer: erase accept window timer, restarted by every accepted erase write
// assumes start_i is the cycle in which the final write strobe is sampled
`timescale 1ns/1ps
module fbpes_timer (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  output logic      expired_o
);
  logic [fbpes_pkg::EAW_W-1:0] cnt;
  logic                        run;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cnt       <= '0;
      run       <= 1'b0;
      expired_o <= 1'b0;
    end else if (start_i) begin
      cnt       <= fbpes_pkg::EAW_CYC;
      run       <= 1'b1;
      expired_o <= 1'b0;
    end else if (run) begin
      cnt <= cnt - fbpes_pkg::EAW_ONE;
      if (cnt == fbpes_pkg::EAW_ONE) begin
        run       <= 1'b0;
        expired_o <= 1'b1;
      end
    end
  end
endmodule

// ===== verilog/fbpes_dev.sv
// fbpes_dev: flash device end, buffered program and multi-sector erase sequencer
// assumes the host keeps to one strobe per cycle on fbpes_if and never reads and writes at once
// How it works
// - program buffer holds at most 32 words
// - host opens with AA, 55, 25 at sector
// - count write gives words minus one, 1..32
// - count above buffer size aborts programming
// - host loads from the command address, ascending addresses
// - load outside the command's sector aborts
// - load outside the chosen 32-word page aborts
// - every load counts down; latest data wins
// - confirm not recognised before all loads done
// - confirm 29 at sector, anything else aborts
// - busy status on bits 7,6,3,2,1, then read
// - program can be suspended and resumed
// - host clears abort with AA, 55, F0@555
// - erase writes zeros, then all ones
// - accept window lets more sectors join
// - window timer starts on final write strobe
// - other command but suspend in window returns to read
// - bit 3 shows accept timer expired
// - other bank reads array, erasing bank status
// - erasing ignores all but suspend; reset stops
// - erase done returns to array read
// - host erases with six write cycles
`timescale 1ns/1ps
module fbpes_dev (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  fbpes_if.dev_mp   bus,
  output logic      busy_o,
  output logic      abort_o
);
  typedef enum logic [3:0] {
    ST_READ, ST_U1, ST_U2, ST_ES, ST_EU1, ST_EU2, ST_CNT, ST_LOAD, ST_CONF,
    ST_PROG, ST_ABORT, ST_AU1, ST_AU2, ST_WIN, ST_ERASE, ST_SUSP
  } fbpes_dst_t;

  fbpes_dst_t                     state;
  logic [fbpes_pkg::DATA_W-1:0]   mem [0:(1<<fbpes_pkg::ADDR_W)-1];
  logic [fbpes_pkg::DATA_W-1:0]   pbuf [0:fbpes_pkg::BUF_WORDS-1];
  logic [fbpes_pkg::BUF_WORDS-1:0] pmask;
  logic [fbpes_pkg::SECT_W-1:0]   wsect;
  logic [fbpes_pkg::PAGE_W-1:0]   wpage;
  logic [fbpes_pkg::IDX_W-1:0]    remain;
  logic [fbpes_pkg::IDX_W-1:0]    prog_idx;
  logic                           first_ld;
  logic [fbpes_pkg::DATA_W-1:0]   last_data;
  logic [fbpes_pkg::SECTS-1:0]    esel;
  logic [fbpes_pkg::SECT_W-1:0]   ers_sect;
  logic [fbpes_pkg::WORD_W-1:0]   ers_word;
  logic                           ers_pass;
  logic                           op_bank;
  logic                           susp_prog;
  logic                           tog;
  logic                           etog;
  logic                           win_expired;
  logic                           timer_start;
  logic                           u1;
  logic                           u2;
  logic                           same_sect;
  logic                           same_page;
  logic                           prog_done;
  logic                           ers_skip;
  logic                           ers_done;
  logic                           aborted;
  logic                           status_hit;
  logic [fbpes_pkg::DATA_W-1:0]   sts;

  function automatic logic [fbpes_pkg::SECT_W-1:0] sect_of(
      input logic [fbpes_pkg::ADDR_W-1:0] a);
    return a[fbpes_pkg::ADDR_W-1 -: fbpes_pkg::SECT_W];
  endfunction

  function automatic logic [fbpes_pkg::PAGE_W-1:0] page_of(
      input logic [fbpes_pkg::ADDR_W-1:0] a);
    return a[fbpes_pkg::ADDR_W-1 -: fbpes_pkg::PAGE_W];
  endfunction

  function automatic logic is_cyc(input logic [fbpes_pkg::ADDR_W-1:0] a,
                                  input logic [fbpes_pkg::DATA_W-1:0] d,
                                  input logic [fbpes_pkg::UNLK_W-1:0] ea,
                                  input logic [fbpes_pkg::DATA_W-1:0] ed);
    return (a[fbpes_pkg::UNLK_W-1:0] == ea) && (d == ed);
  endfunction

  assign u1        = is_cyc(bus.addr, bus.wdata, fbpes_pkg::ADR_UNLK1, fbpes_pkg::CMD_UNLK1);
  assign u2        = is_cyc(bus.addr, bus.wdata, fbpes_pkg::ADR_UNLK2, fbpes_pkg::CMD_UNLK2);
  assign same_sect = sect_of(bus.addr) == wsect;
  assign same_page = page_of(bus.addr) == wpage;
  assign prog_done = prog_idx == fbpes_pkg::IDX_LAST;
  assign ers_skip  = !esel[ers_sect] || (ers_pass && ers_word == fbpes_pkg::SECT_LAST);
  assign ers_done  = ers_skip && ers_sect == fbpes_pkg::SECT_MAX;
  assign aborted   = state inside {ST_ABORT, ST_AU1, ST_AU2};
  // both the first erase command and each later add restart the window
  assign timer_start = bus.wr && bus.wdata == fbpes_pkg::CMD_SECT_ERASE
                       && state inside {ST_EU2, ST_WIN};

  fbpes_timer u_timer (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .start_i    (timer_start),
    .expired_o  (win_expired)
  );

  // command decoder; a synchronous reset ends any operation at once
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= ST_READ;
    end else if (bus.wr) begin
      unique case (state)
        ST_READ:  state <= u1 ? ST_U1 : ST_READ;
        ST_U1:    state <= u2 ? ST_U2 : ST_READ;
        ST_U2: begin
          if (bus.wdata == fbpes_pkg::CMD_BUF_LOAD) state <= ST_CNT;
          else if (bus.wdata == fbpes_pkg::CMD_ERASE_SETUP) state <= ST_ES;
          else state <= ST_READ;
        end
        ST_ES:    state <= u1 ? ST_EU1 : ST_READ;
        ST_EU1:   state <= u2 ? ST_EU2 : ST_READ;
        ST_EU2:   state <= timer_start ? ST_WIN : ST_READ;
        ST_CNT: begin
          if (bus.wdata > fbpes_pkg::BUF_MAX_CNT || !same_sect) state <= ST_ABORT;
          else state <= ST_LOAD;
        end
        ST_LOAD: begin
          if (!same_sect || (!first_ld && !same_page)) state <= ST_ABORT;
          else if (remain == '0) state <= ST_CONF;
        end
        ST_CONF: begin
          if (bus.wdata == fbpes_pkg::CMD_CONFIRM && same_sect) state <= ST_PROG;
          else state <= ST_ABORT;
        end
        ST_PROG:  if (bus.wdata == fbpes_pkg::CMD_SUSPEND) state <= ST_SUSP;
        ST_ABORT: state <= u1 ? ST_AU1 : ST_ABORT;
        ST_AU1:   state <= u2 ? ST_AU2 : ST_ABORT;
        ST_AU2: begin
          if (is_cyc(bus.addr, bus.wdata, fbpes_pkg::ADR_UNLK1, fbpes_pkg::CMD_RESET)) begin
            state <= ST_READ;
          end else begin
            state <= ST_ABORT;
          end
        end
        ST_WIN: begin
          if (bus.wdata == fbpes_pkg::CMD_SUSPEND) state <= ST_SUSP;
          else if (!timer_start) state <= ST_READ;
        end
        ST_ERASE: if (bus.wdata == fbpes_pkg::CMD_SUSPEND) state <= ST_SUSP;
        ST_SUSP: begin
          if (bus.wdata == fbpes_pkg::CMD_RESUME) state <= susp_prog ? ST_PROG : ST_ERASE;
        end
      endcase
    end else if (state == ST_WIN && win_expired) begin
      state <= ST_ERASE;
    end else if (state == ST_PROG && prog_done) begin
      state <= ST_READ;
    end else if (state == ST_ERASE && ers_done) begin
      state <= ST_READ;
    end
  end

  // which operation a suspend belongs to, and which bank shows status
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      susp_prog <= 1'b0;
      op_bank   <= 1'b0;
    end else begin
      if (bus.wr && bus.wdata == fbpes_pkg::CMD_SUSPEND && state != ST_SUSP) begin
        susp_prog <= state == ST_PROG;
      end
      if (timer_start || (bus.wr && state == ST_U2)) op_bank <= bus.addr[fbpes_pkg::BANK_BIT];
    end
  end

  // load bookkeeping: the counter drops on every load, repeats included
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wsect     <= '0;
      wpage     <= '0;
      remain    <= '0;
      first_ld  <= 1'b0;
      pmask     <= '0;
      last_data <= '0;
    end else if (bus.wr) begin
      if (state == ST_U2) begin
        wsect    <= sect_of(bus.addr);
        pmask    <= '0;
        first_ld <= 1'b1;
      end
      if (state == ST_CNT) remain <= bus.wdata[fbpes_pkg::IDX_W-1:0];
      if (state == ST_LOAD) begin
        first_ld  <= 1'b0;
        if (first_ld) wpage <= page_of(bus.addr);
        remain    <= remain - 1'b1;
        pmask[bus.addr[fbpes_pkg::IDX_W-1:0]] <= 1'b1;
        last_data <= bus.wdata;
      end
    end
  end

  // buffer keeps the newest word per location
  always_ff @(posedge core_clk_i) begin
    if (bus.wr && state == ST_LOAD) pbuf[bus.addr[fbpes_pkg::IDX_W-1:0]] <= bus.wdata;
  end

  // a suspend restarts the walk; re-programming the same zeros is harmless
  always_ff @(posedge core_clk_i) begin
    if (reset_i || state != ST_PROG) prog_idx <= '0;
    else prog_idx <= prog_idx + 1'b1;
  end

  // erase walk: skip unselected sectors, zero pass then ones pass
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      esel     <= '0;
      ers_sect <= '0;
      ers_word <= '0;
      ers_pass <= 1'b0;
    end else if (timer_start) begin
      esel[sect_of(bus.addr)] <= 1'b1;
      ers_sect <= '0;
      ers_word <= '0;
      ers_pass <= 1'b0;
    end else if (state == ST_READ) begin
      esel <= '0;
    end else if (state == ST_ERASE) begin
      if (ers_skip) begin
        ers_sect <= ers_sect + 1'b1;
        ers_word <= '0;
        ers_pass <= 1'b0;
      end else begin
        ers_word <= ers_word + 1'b1;
        if (ers_word == fbpes_pkg::SECT_LAST) ers_pass <= 1'b1;
      end
    end
  end

  // array: programming only clears bits, erase sets zeros then ones
  always_ff @(posedge core_clk_i) begin
    if (state == ST_PROG && pmask[prog_idx]) begin
      mem[{wpage, prog_idx}] <= mem[{wpage, prog_idx}] & pbuf[prog_idx];
    end else if (state == ST_ERASE && esel[ers_sect]) begin
      mem[{ers_sect, ers_word}] <= ers_pass ? fbpes_pkg::ERASED_WORD
                                            : fbpes_pkg::ZERO_WORD;
    end
  end

  always_comb begin
    status_hit = 1'b0;
    if (state inside {ST_PROG, ST_WIN, ST_ERASE} || aborted) begin
      status_hit = bus.addr[fbpes_pkg::BANK_BIT] == op_bank;
    end else if (state == ST_SUSP) begin
      status_hit = susp_prog ? 1'b0 : esel[sect_of(bus.addr)];
    end
  end

  // time limit failure is not modelled, so that bit reads zero
  always_comb begin
    sts = fbpes_pkg::ZERO_WORD;
    sts[fbpes_pkg::STS_POLL] = (state == ST_SUSP) ||
                               ((state == ST_PROG || aborted) && !last_data[fbpes_pkg::STS_POLL]);
    sts[fbpes_pkg::STS_TOG]  = tog;
    sts[fbpes_pkg::STS_EAT]  = state == ST_ERASE || state == ST_SUSP;
    sts[fbpes_pkg::STS_ETOG] = etog;
    sts[fbpes_pkg::STS_BABT] = aborted;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      bus.rdata <= fbpes_pkg::ZERO_WORD;
      tog       <= 1'b0;
      etog      <= 1'b0;
    end else if (bus.rd) begin
      bus.rdata <= status_hit ? sts : mem[bus.addr];
      if (status_hit && state != ST_SUSP) tog <= !tog;
      if (status_hit && state inside {ST_WIN, ST_ERASE, ST_SUSP}) etog <= !etog;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      busy_o  <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      busy_o  <= state inside {ST_PROG, ST_WIN, ST_ERASE};
      abort_o <= aborted;
    end
  end
endmodule

// ===== verilog/fbpes_host.sv
// fbpes_host: host controller end, turns user orders into flash command cycles
// assumes the user paces erase adds inside the accept window and loads one page in order
`timescale 1ns/1ps
module fbpes_host (
  input  wire logic                         core_clk_i,
  input  wire logic                         reset_i,
  fbpes_if.host_mp                          bus,
  input  wire logic                         cmd_valid_i,
  input  wire fbpes_pkg::fbpes_op_t         cmd_op_i,
  input  wire logic [fbpes_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [fbpes_pkg::IDX_W-1:0]  cmd_count_i,
  output logic                              cmd_ready_o,
  input  wire logic                         ld_valid_i,
  input  wire logic [fbpes_pkg::DATA_W-1:0] ld_data_i,
  output logic                              ld_ready_o,
  output logic [fbpes_pkg::DATA_W-1:0]      rd_data_o,
  output logic                              rd_valid_o,
  output logic                              done_o
);
  typedef enum logic [2:0] {H_IDLE, H_SEQ, H_LOAD, H_CONF, H_PRD, H_RW, H_PCAP, H_RCAP} fbpes_hst_t;

  fbpes_hst_t                    state;
  fbpes_pkg::fbpes_op_t          op;
  logic [fbpes_pkg::ADDR_W-1:0]  base;
  logic [fbpes_pkg::ADDR_W-1:0]  cur;
  logic [fbpes_pkg::ADDR_W-1:0]  last;
  logic [fbpes_pkg::IDX_W-1:0]   count;
  logic [fbpes_pkg::IDX_W-1:0]   remain;
  logic [2:0]                    step;
  logic                          prev_tog;
  logic                          have_prev;

  function automatic logic [2:0] seq_last(input fbpes_pkg::fbpes_op_t o);
    unique case (o)
      fbpes_pkg::OP_BUF_PROG:  return 3'h3;
      fbpes_pkg::OP_ERASE:     return 3'h5;
      fbpes_pkg::OP_ABORT_RST: return 3'h2;
      default:                 return 3'h0;
    endcase
  endfunction

  function automatic logic [fbpes_pkg::ADDR_W+fbpes_pkg::DATA_W-1:0] seq_word(
      input fbpes_pkg::fbpes_op_t o, input logic [2:0] st,
      input logic [fbpes_pkg::ADDR_W-1:0] a, input logic [fbpes_pkg::IDX_W-1:0] n);
    logic [fbpes_pkg::ADDR_W-1:0] ua1;
    logic [fbpes_pkg::ADDR_W-1:0] ua2;
    ua1 = {a[fbpes_pkg::BANK_BIT], fbpes_pkg::ADR_UNLK1};
    ua2 = {a[fbpes_pkg::BANK_BIT], fbpes_pkg::ADR_UNLK2};
    if (o == fbpes_pkg::OP_SUSPEND) return {a, fbpes_pkg::CMD_SUSPEND};
    if (o == fbpes_pkg::OP_RESUME) return {a, fbpes_pkg::CMD_RESUME};
    if (o == fbpes_pkg::OP_ERASE_ADD) return {a, fbpes_pkg::CMD_SECT_ERASE};
    if (st == 3'h0 || (o == fbpes_pkg::OP_ERASE && st == 3'h3)) return {ua1, fbpes_pkg::CMD_UNLK1};
    if (st == 3'h1 || (o == fbpes_pkg::OP_ERASE && st == 3'h4)) return {ua2, fbpes_pkg::CMD_UNLK2};
    if (o == fbpes_pkg::OP_BUF_PROG) begin
      if (st == 3'h2) return {a, fbpes_pkg::CMD_BUF_LOAD};
      return {a, fbpes_pkg::DATA_W'(n)};
    end
    if (o == fbpes_pkg::OP_ABORT_RST) return {ua1, fbpes_pkg::CMD_RESET};
    if (st == 3'h2) return {ua1, fbpes_pkg::CMD_ERASE_SETUP};
    return {a, fbpes_pkg::CMD_SECT_ERASE};
  endfunction

  assign cmd_ready_o = state == H_IDLE;
  assign ld_ready_o  = state == H_LOAD;

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state      <= H_IDLE;
      op         <= fbpes_pkg::OP_READ;
      base       <= '0;
      cur        <= '0;
      last       <= '0;
      count      <= '0;
      remain     <= '0;
      step       <= '0;
      prev_tog   <= 1'b0;
      have_prev  <= 1'b0;
      bus.wr     <= 1'b0;
      bus.rd     <= 1'b0;
      bus.addr   <= '0;
      bus.wdata  <= fbpes_pkg::ZERO_WORD;
      rd_data_o  <= fbpes_pkg::ZERO_WORD;
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
    end else begin
      bus.wr     <= 1'b0;
      bus.rd     <= 1'b0;
      rd_valid_o <= 1'b0;
      done_o     <= 1'b0;
      unique case (state)
        H_IDLE: if (cmd_valid_i) begin
          op    <= cmd_op_i;
          base  <= cmd_addr_i;
          count <= cmd_count_i;
          step  <= '0;
          if (cmd_op_i == fbpes_pkg::OP_READ) begin
            bus.rd   <= 1'b1;
            bus.addr <= cmd_addr_i;
            state    <= H_RW;
          end else begin
            state <= H_SEQ;
          end
        end
        H_SEQ: begin
          {bus.addr, bus.wdata} <= seq_word(op, step, base, count);
          bus.wr <= 1'b1;
          step   <= step + 1'b1;
          if (step == seq_last(op)) begin
            if (op == fbpes_pkg::OP_BUF_PROG) begin
              state  <= H_LOAD;
              cur    <= base;
              remain <= count;
            end else begin
              state  <= H_IDLE;
              done_o <= 1'b1;
            end
          end
        end
        // the user's first word goes to the command address; later loads must stay in its page
        H_LOAD: if (ld_valid_i) begin
          bus.wr    <= 1'b1;
          bus.addr  <= cur;
          bus.wdata <= ld_data_i;
          last      <= cur;
          cur       <= cur + 1'b1;
          remain    <= remain - 1'b1;
          if (remain == '0) state <= H_CONF;
        end
        H_CONF: begin
          bus.wr    <= 1'b1;
          bus.addr  <= last;
          bus.wdata <= fbpes_pkg::CMD_CONFIRM;
          have_prev <= 1'b0;
          state     <= H_PRD;
        end
        H_PRD: begin
          bus.rd   <= 1'b1;
          bus.addr <= last;
          state    <= H_RW;
        end
        H_RW: state <= (op == fbpes_pkg::OP_READ) ? H_RCAP : H_PCAP;
        // polling ends when the toggle bit stops or the abort bit shows
        H_PCAP: begin
          prev_tog  <= bus.rdata[fbpes_pkg::STS_TOG];
          have_prev <= 1'b1;
          if (have_prev && (prev_tog == bus.rdata[fbpes_pkg::STS_TOG]
                            || bus.rdata[fbpes_pkg::STS_BABT])) begin
            rd_data_o <= bus.rdata;
            done_o    <= 1'b1;
            state     <= H_IDLE;
          end else begin
            state <= H_PRD;
          end
        end
        H_RCAP: begin
          rd_data_o  <= bus.rdata;
          rd_valid_o <= 1'b1;
          state      <= H_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== tb/fbpes_props.sv
// fbpes_props: timing checks on the flash command link and the device flags
// assumes one clock, synchronous active-high reset; fed plain link signals
`timescale 1ns/1ps
module fbpes_props (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        busy_o,
  input  wire logic        abort_o
);
  logic [5:0] sect_q;
  logic       unlk2_q;
  logic       rst_q;
  logic       obank;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge core_clk_i) begin
    sect_q  <= addr[11:6];
    unlk2_q <= wr && wdata == fbpes_pkg::CMD_UNLK2;
    rst_q   <= wr && wdata == fbpes_pkg::CMD_RESET;
    // only the bank that took the command returns status, others return array words
    if (wr && wdata inside {fbpes_pkg::CMD_BUF_LOAD, fbpes_pkg::CMD_ERASE_SETUP})
      obank <= addr[11];
  end
  property p_one_strobe; !(wr && rd); endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("read and write strobes together");
  property p_unlock_pair;
    wr && wdata == fbpes_pkg::CMD_UNLK1 |=> wr && wdata == fbpes_pkg::CMD_UNLK2
      && addr[10:0] == fbpes_pkg::ADR_UNLK2;
  endproperty
  a_unlock_pair: assert property (p_unlock_pair) else $error("second unlock missing");
  property p_count_sector;
    wr && wdata == fbpes_pkg::CMD_BUF_LOAD |=> wr && addr[11:6] == sect_q;
  endproperty
  a_count_sector: assert property (p_count_sector) else $error("count not at sector");
  // window plus erase lasts far beyond eight cycles, so busy must hold
  property p_window_busy;
    wr && wdata == fbpes_pkg::CMD_SECT_ERASE && unlk2_q |-> ##2 busy_o [*8];
  endproperty
  a_window_busy: assert property (p_window_busy) else $error("no window after erase");
  property p_eat_low;
    wr && wdata == fbpes_pkg::CMD_SECT_ERASE && unlk2_q ##[1:20] rd && addr[11] == obank
      |=> !busy_o || !rdata[3];
  endproperty
  a_eat_low: assert property (p_eat_low) else $error("accept timer shown expired early");
  property p_tle_low;
    rd && addr[11] == obank |=> !busy_o || !rdata[fbpes_pkg::STS_TLE];
  endproperty
  a_tle_low: assert property (p_tle_low) else $error("time limit bit set");
  property p_confirm_busy;
    wr && wdata == fbpes_pkg::CMD_CONFIRM && !abort_o |-> ##2 busy_o [*4];
  endproperty
  a_confirm_busy: assert property (p_confirm_busy) else $error("not busy after confirm");
  property p_abort_hold;
    abort_o && !rst_q && !(wr && wdata == fbpes_pkg::CMD_RESET) |=> abort_o;
  endproperty
  a_abort_hold: assert property (p_abort_hold) else $error("abort left without reset");
  property p_abort_idle; abort_o |-> !busy_o; endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("busy while aborted");
  c_confirm: cover property (wr && wdata == fbpes_pkg::CMD_CONFIRM);
  c_abort: cover property ($rose(abort_o));
  c_done: cover property ($fell(busy_o));
endmodule

// ===== tb/testbench.sv
// testbench: host and device ends joined; user orders in, read data checked from a queue
// assumes the array starts unknown, so only erased or programmed words are read back
`timescale 1ns/1ps
module testbench;
  logic                 core_clk_i = 1'b0;
  logic                 reset_i    = 1'b1;
  logic                 cmd_valid  = 1'b0;
  logic                 ld_valid   = 1'b0;
  fbpes_pkg::fbpes_op_t cmd_op     = fbpes_pkg::OP_READ;
  logic [11:0]          cmd_addr   = 12'h000;
  logic [4:0]           cmd_count  = 5'h00;
  logic [15:0]          ld_data    = 16'h0000;
  logic [15:0]          rd_data, w;
  logic                 cmd_ready, ld_ready, rd_valid, done, busy, abort;
  logic [31:0]          e;
  logic [31:0]          expq [$];
  logic [15:0]          img [logic [11:0]];
  int                   failures = 0, n_compared = 0, cyc = 0;
  fbpes_if bus ();
  fbpes_dev i_fbpes_dev (.core_clk_i, .reset_i, .bus(bus.dev_mp), .busy_o(busy), .abort_o(abort));
  fbpes_host i_fbpes_host (.core_clk_i, .reset_i, .bus(bus.host_mp), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_count_i(cmd_count), .cmd_ready_o(cmd_ready),
    .ld_valid_i(ld_valid), .ld_data_i(ld_data), .ld_ready_o(ld_ready), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .done_o(done));
  fbpes_props i_fbpes_props (.core_clk_i, .reset_i, .wr(bus.wr), .rd(bus.rd), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .busy_o(busy), .abort_o(abort));
  initial forever #25 core_clk_i = ~core_clk_i;
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  always @(posedge core_clk_i) if (rd_valid === 1'b1) begin
    e = expq.pop_front();
    check("read data", rd_data & e[31:16], e[15:0]);
  end
  task automatic order(input fbpes_pkg::fbpes_op_t op, input logic [11:0] a, input logic [4:0] n);
    @(posedge core_clk_i);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_count <= n;
    cmd_valid <= 1'b1;
    do @(posedge core_clk_i); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  task wait_done; do @(posedge core_clk_i); while (done !== 1'b1); endtask
  task wait_idle; do @(posedge core_clk_i); while (busy !== 1'b0); endtask
  task automatic rd_exp(input logic [11:0] a, input logic [15:0] m, input logic [15:0] x);
    expq.push_back({m, x});
    order(fbpes_pkg::OP_READ, a, 5'h00);
  endtask
  // load data keeps bit 15 set, so no word looks like a command code
  task automatic prog(input logic [11:0] a, input logic [4:0] n);
    order(fbpes_pkg::OP_BUF_PROG, a, n);
    for (int i = 0; i <= int'(n); i++) begin
      w = 16'($urandom) | 16'h8000;
      img[12'(a + i)] = w;
      ld_data <= w;
      ld_valid <= 1'b1;
      do @(posedge core_clk_i); while (ld_ready !== 1'b1);
    end
    ld_valid <= 1'b0;
    wait_done();
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    void'($urandom(6));
    order(fbpes_pkg::OP_ERASE, 12'h000, 5'h00);
    wait_done();
    rd_exp(12'h000, 16'h00AA, 16'h0000);
    order(fbpes_pkg::OP_ERASE_ADD, 12'h040, 5'h00);
    wait_done();
    wait_idle();
    rd_exp(12'h07F, 16'hFFFF, 16'hFFFF);
    prog(12'h020, 5'h1F);
    prog(12'h040, 5'($urandom));
    for (int i = 0; i < 32; i++) rd_exp(12'(12'h020 + i), 16'hFFFF, img[12'(12'h020 + i)]);
    rd_exp(12'h040, 16'hFFFF, img[12'h040]);
    order(fbpes_pkg::OP_ERASE, 12'h880, 5'h00);
    wait_done();
    rd_exp(12'h880, 16'h00AA, 16'h0000);
    rd_exp(12'h020, 16'hFFFF, img[12'h020]);
    order(fbpes_pkg::OP_SUSPEND, 12'h880, 5'h00);
    wait_done();
    rd_exp(12'h880, 16'h00AA, 16'h0088);
    order(fbpes_pkg::OP_RESUME, 12'h880, 5'h00);
    wait_done();
    repeat (2) @(posedge core_clk_i);
    wait_idle();
    rd_exp(12'h8BF, 16'hFFFF, 16'hFFFF);
    prog(12'h07E, 5'h03);
    check("abort flag", {15'h0000, abort}, 16'h0001);
    order(fbpes_pkg::OP_ABORT_RST, 12'h000, 5'h00);
    wait_done();
    repeat (2) @(posedge core_clk_i);
    check("abort flag", {15'h0000, abort}, 16'h0000);
    order(fbpes_pkg::OP_ERASE, 12'h880, 5'h00);
    wait_done();
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    check("busy flag", {15'h0000, busy}, 16'h0000);
    rd_exp(12'h07E, 16'hFFFF, 16'hFFFF);
    repeat (8) @(posedge core_clk_i);
    check("reads left", 16'(expq.size()), 16'h0000);
    complete_run();
  end
endmodule
